// file: rtcal_params.svh
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RTCAL_OFS_CTRL     8'h00
`define RTCAL_OFS_ACCESS   8'h04
`define RTCAL_OFS_TIME     8'h0C
`define RTCAL_OFS_CAL      8'h10
`define RTCAL_OFS_FMT      8'h14
`define RTCAL_OFS_WDAY     8'h18
`define RTCAL_OFS_TALM     8'h1C
`define RTCAL_OFS_CALM     8'h20
`define RTCAL_OFS_LEAP     8'h24
`define RTCAL_OFS_IEN      8'h28
`define RTCAL_OFS_ISTS     8'h2C
`define RTCAL_OFS_ICLR     8'h34

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define RTCAL_RST_CAL      24'h050101
`define RTCAL_RST_TIME     24'h000000
`define RTCAL_RST_FMT      1'b1
`define RTCAL_RST_WDAY     3'h6
`define RTCAL_RST_ALARM    24'h000000
`define RTCAL_DATE_MASK    24'hFF1F3F
`define RTCAL_TIME_MASK    24'h3F7F7F
`define RTCAL_ACCESS_FLAG_BIT 16

// ----------------------------------------------------------------
// Access window and timing
// ----------------------------------------------------------------
`define RTCAL_PASSWORD     16'hA965
`define RTCAL_ACCESS_CYCLES 10'h200
`define RTCAL_SECOND_NS    1000000000
`define RTCAL_PCLK_NS      100
`define RTCAL_SECOND_CYCLES (`RTCAL_SECOND_NS / `RTCAL_PCLK_NS)

`endif

// file: rtcal_pkg.sv
`default_nettype none

package rtcal_pkg;

    typedef struct packed {
        logic [3:0] year_tens_digit;
        logic [3:0] year_units_digit;
        logic [2:0] rsv_a;
        logic       mth_tens_digit;
        logic [3:0] mth_units_digit;
        logic [1:0] rsv_b;
        logic [1:0] day_tens_digit;
        logic [3:0] day_units_digit;
    } rtcal_date_t;

    typedef struct packed {
        logic [1:0] rsv_a;
        logic [1:0] hour_tens_digit;
        logic [3:0] hour_units_digit;
        logic       rsv_b;
        logic [2:0] mnt_tens_digit;
        logic [3:0] mnt_units_digit;
        logic       rsv_c;
        logic [2:0] scnd_tens_digit;
        logic [3:0] scnd_units_digit;
    } rtcal_time_t;

    typedef struct packed {
        logic        active;
        logic        fmt24;
        logic [2:0]  wday;
        rtcal_time_t tod;
        rtcal_date_t cal;
        rtcal_time_t talm;
        rtcal_date_t calm;
        logic        wen;
        logic [9:0]  wcnt;
        logic        ien;
        logic        flag;
        logic        match_q;
        logic        leap;
        logic [31:0] rdata;
    } rtcal_state_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } rtcal_div_t;

endpackage

`default_nettype wire

// file: rtcal_tick_div.sv
`timescale 1ns/1ps
`default_nettype none

module rtcal_tick_div #(
    parameter int unsigned CYCLES = 10000000
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control and pulse
    input  wire logic run,
    output logic      tick
);
    rtcal_pkg::rtcal_div_t s;
    rtcal_pkg::rtcal_div_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!run) begin
            next_s.cnt = 32'h0;
        end else if (s.cnt == 32'(CYCLES - 1)) begin
            next_s.cnt = 32'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule

`default_nettype wire

// file: rtcal_cal_step.sv
`timescale 1ns/1ps
`default_nettype none

module rtcal_cal_step (
    // Current calendar
    input  wire logic                  [2:0] wday,
    input  wire rtcal_pkg::rtcal_date_t      cal,
    // Following day, and leap flag of the current year
    output logic                       [2:0] next_wday,
    output var rtcal_pkg::rtcal_date_t       next_cal,
    output logic                             leap
);
    logic [6:0] year_bin;
    logic [4:0] mth_bin;
    logic [7:0] last_day;
    logic [7:0] day_bcd;

    assign year_bin = (7'(cal.year_tens_digit) * 7'h0A) + 7'(cal.year_units_digit);
    assign mth_bin  = (5'(cal.mth_tens_digit) * 5'h0A) + 5'(cal.mth_units_digit);
    assign leap     = (year_bin[1:0] == 2'h0);
    assign day_bcd  = {2'h0, cal.day_tens_digit, cal.day_units_digit};
    assign next_wday = (wday >= 3'h6) ? 3'h0 : wday + 3'h1; // R18 R8

    always_comb begin
        unique case (mth_bin)
            5'h02:                      last_day = leap ? 8'h29 : 8'h28; // R18
            5'h04, 5'h06, 5'h09, 5'h0B: last_day = 8'h30;
            default:                    last_day = 8'h31;
        endcase
        next_cal = cal;
        if (day_bcd >= last_day) begin
            next_cal.day_tens_digit  = 2'h0;
            next_cal.day_units_digit = 4'h1;
            if (mth_bin >= 5'h0C) begin
                next_cal.mth_tens_digit  = 1'b0;
                next_cal.mth_units_digit = 4'h1;
                if (cal.year_units_digit == 4'h9) begin
                    next_cal.year_units_digit = 4'h0;
                    next_cal.year_tens_digit  = (cal.year_tens_digit == 4'h9) ? 4'h0
                                              : cal.year_tens_digit + 4'h1;
                end else begin
                    next_cal.year_units_digit = cal.year_units_digit + 4'h1;
                end
            end else if (cal.mth_units_digit == 4'h9) begin
                next_cal.mth_tens_digit  = 1'b1;
                next_cal.mth_units_digit = 4'h0;
            end else begin
                next_cal.mth_units_digit = cal.mth_units_digit + 4'h1;
            end
        end else if (cal.day_units_digit == 4'h9) begin
            next_cal.day_tens_digit  = cal.day_tens_digit + 2'h1;
            next_cal.day_units_digit = 4'h0;
        end else begin
            next_cal.day_units_digit = cal.day_units_digit + 4'h1;
        end
    end
endmodule

`default_nettype wire

// file: rtcal_regs.sv
// Operation
// R1 - Date writes ignored without access password
// R2 - Date read returns running calendar
// R3 - Date held as BCD digit fields
// R4 - Format bit selects 24 or 12 hour
// R5 - 24-hour mode counts 0 to 23
// R6 - Morning hours coded 01 to 12
// R7 - Afternoon hours coded 21 to 32
// R8 - Weekday 0 Sunday through 6 Saturday
// R9 - Time alarm held as BCD digits
// R10 - Alarm digits stored without range check
// R11 - Alarms read back only when active
// R12 - Date alarm uses date layout
// R13 - Leap indicator read-only, resets zero
// R14 - Password 0xA965 opens 512-cycle window
// R15 - Alarm match sets flag, write clears (here the flag sets only while ien is set)
// R16 - Leap bit shows current leap year
// R17 - Time counter BCD, loads unchecked
// R18 - Weekday and date advance with rollover
// R19 - Alarm compares in current hour format
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rtcal_params.svh"

module rtcal_regs #(
    parameter int unsigned SECOND_CYCLES = `RTCAL_SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq_alarm
);
    // ------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------
    localparam rtcal_pkg::rtcal_state_t RST = '{
        active:  1'b0,
        fmt24:   `RTCAL_RST_FMT,
        wday:    `RTCAL_RST_WDAY,
        tod:     `RTCAL_RST_TIME,
        cal:     `RTCAL_RST_CAL,
        talm:    `RTCAL_RST_ALARM,
        calm:    `RTCAL_RST_ALARM,
        wen:     1'b0,
        wcnt:    10'h000,
        ien:     1'b0,
        flag:    1'b0,
        match_q: 1'b0,
        leap:    1'b0,
        rdata:   32'h00000000
    };

    rtcal_pkg::rtcal_state_t s;
    rtcal_pkg::rtcal_state_t next_s;
    rtcal_pkg::rtcal_date_t  step_cal;
    logic [2:0]              step_wday;
    logic                    step_leap;
    logic                    tick;
    logic                    wr;
    logic                    rd_setup;
    logic                    mapped;
    logic                    match;
    logic                    alarm_set;
    logic                    alarm_clr;
    logic                    wr_tod;

    function automatic logic [6:0] inc_sixty(input logic [6:0] v, output logic carry);
        logic [6:0] r;
        r = v;
        carry = 1'b0;
        if (v[3:0] != 4'h9) begin
            r[3:0] = v[3:0] + 4'h1;
        end else if (v[6:4] != 3'h5) begin
            r = {v[6:4] + 3'h1, 4'h0};
        end else begin
            r = 7'h00;
            carry = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [5:0] bcd_hour_inc(input logic [5:0] h);
        logic [5:0] r;
        r = (h[3:0] == 4'h9) ? {h[5:4] + 2'h1, 4'h0} : {h[5:4], h[3:0] + 4'h1};
        return r;
    endfunction

    function automatic logic [5:0] next_hour(input logic [5:0] h, input logic fmt24,
                                             output logic day_roll);
        logic [5:0] r;
        day_roll = 1'b0;
        r = bcd_hour_inc(h);
        if (fmt24) begin
            if (h == 6'h23) begin                     // R5
                r = 6'h00;
                day_roll = 1'b1;
            end
        end else begin
            unique case (h)
                6'h12:   r = 6'h01;                   // R6
                6'h11:   r = 6'h32;                   // R7
                6'h32:   r = 6'h21;                   // R7
                6'h31: begin
                    r = 6'h12;
                    day_roll = 1'b1;
                end
                default: r = bcd_hour_inc(h);
            endcase
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic m;
        unique case (a)
            `RTCAL_OFS_CTRL, `RTCAL_OFS_ACCESS, `RTCAL_OFS_TIME, `RTCAL_OFS_CAL,
            `RTCAL_OFS_FMT, `RTCAL_OFS_WDAY, `RTCAL_OFS_TALM, `RTCAL_OFS_CALM,
            `RTCAL_OFS_LEAP, `RTCAL_OFS_IEN, `RTCAL_OFS_ISTS,
            `RTCAL_OFS_ICLR: m = 1'b1;
            default:         m = 1'b0;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // Second tick and day step
    // ------------------------------------------------------------
    rtcal_tick_div #(
        .CYCLES (SECOND_CYCLES)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (s.active),
        .tick    (tick)
    );

    rtcal_cal_step u_step (
        .wday      (s.wday),
        .cal       (s.cal),
        .next_wday (step_wday),
        .next_cal  (step_cal),
        .leap      (step_leap)
    );

    // ------------------------------------------------------------
    // Bus decode and alarm compare
    // ------------------------------------------------------------
    assign wr        = psel && penable && pwrite && mapped;
    assign rd_setup  = psel && !penable && !pwrite;
    assign mapped    = is_mapped(paddr);
    assign wr_tod    = wr && s.wen && (paddr == `RTCAL_OFS_TIME);
    assign match     = s.active && (s.tod == s.talm) && (s.cal == s.calm); // R19 R15
    assign alarm_clr = wr && (paddr == `RTCAL_OFS_ICLR) && pwdata[0];
    assign alarm_set = match && !s.match_q && s.ien;                     // R15

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       c_sec;
        logic       c_min;
        logic       c_day;
        logic [6:0] sec_v;
        logic [6:0] min_v;
        logic [5:0] hour_v;
        c_sec  = 1'b0;
        c_min  = 1'b0;
        c_day  = 1'b0;
        sec_v  = 7'h00;
        min_v  = 7'h00;
        hour_v = 6'h00;
        next_s = s;
        next_s.match_q = match;
        next_s.leap    = step_leap;                   // R16 R13

        // Access window cycle count, counting up
        if (s.wen) begin
            if (s.wcnt == `RTCAL_ACCESS_CYCLES - 10'h001) begin
                next_s.wen = 1'b0;                    // R14
            end else begin
                next_s.wcnt = s.wcnt + 10'h001;
            end
        end

        // Running time and calendar
        if (tick && s.active) begin
            sec_v = inc_sixty({s.tod.scnd_tens_digit, s.tod.scnd_units_digit}, c_sec);
            next_s.tod.scnd_tens_digit  = sec_v[6:4];
            next_s.tod.scnd_units_digit = sec_v[3:0];
            if (c_sec) begin
                min_v = inc_sixty({s.tod.mnt_tens_digit, s.tod.mnt_units_digit}, c_min);
                next_s.tod.mnt_tens_digit  = min_v[6:4];
                next_s.tod.mnt_units_digit = min_v[3:0];
            end
            if (c_min) begin
                hour_v = next_hour({s.tod.hour_tens_digit, s.tod.hour_units_digit},
                                   s.fmt24, c_day);   // R4
                next_s.tod.hour_tens_digit  = hour_v[5:4];
                next_s.tod.hour_units_digit = hour_v[3:0];
            end
            if (c_day) begin
                next_s.cal  = step_cal;               // R18
                next_s.wday = step_wday;              // R18 R8
            end
        end

        // Register writes
        if (wr) begin
            unique case (paddr)
                `RTCAL_OFS_CTRL: next_s.active = pwdata[0];
                `RTCAL_OFS_ACCESS: begin
                    next_s.wen  = (pwdata[15:0] == `RTCAL_PASSWORD); // R14
                    next_s.wcnt = 10'h000;
                end
                `RTCAL_OFS_TIME: if (s.wen) begin
                    next_s.tod = pwdata[23:0] & `RTCAL_TIME_MASK; // R17
                end
                `RTCAL_OFS_CAL: if (s.wen) begin                  // R1
                    next_s.cal = pwdata[23:0] & `RTCAL_DATE_MASK; // R3
                end
                `RTCAL_OFS_FMT: if (s.wen) begin
                    next_s.fmt24 = pwdata[0];                     // R4
                end
                `RTCAL_OFS_WDAY: if (s.wen) begin
                    next_s.wday = pwdata[2:0];                    // R8
                end
                `RTCAL_OFS_TALM: if (s.wen) begin
                    next_s.talm = pwdata[23:0] & `RTCAL_TIME_MASK; // R9 R10
                end
                `RTCAL_OFS_CALM: if (s.wen) begin
                    next_s.calm = pwdata[23:0] & `RTCAL_DATE_MASK; // R12 R10
                end
                `RTCAL_OFS_IEN: next_s.ien = pwdata[0];
                default: ;
            endcase
        end

        // Sticky alarm flag, set wins over clear
        next_s.flag = alarm_set || (s.flag && !alarm_clr); // R15

        // Read data captured in the setup cycle
        if (rd_setup) begin
            unique case (paddr)
                `RTCAL_OFS_CTRL:   next_s.rdata = {31'h0, s.active};
                `RTCAL_OFS_ACCESS: next_s.rdata = 32'(s.wen) << `RTCAL_ACCESS_FLAG_BIT;
                `RTCAL_OFS_TIME:   next_s.rdata = {8'h00, s.tod};
                `RTCAL_OFS_CAL:    next_s.rdata = {8'h00, s.cal};  // R2
                `RTCAL_OFS_FMT:    next_s.rdata = {31'h0, s.fmt24};
                `RTCAL_OFS_WDAY:   next_s.rdata = {29'h0, s.wday};
                `RTCAL_OFS_TALM:   next_s.rdata = s.active ? {8'h00, s.talm} : 32'h0; // R11
                `RTCAL_OFS_CALM:   next_s.rdata = s.active ? {8'h00, s.calm} : 32'h0; // R11
                `RTCAL_OFS_LEAP:   next_s.rdata = {31'h0, s.leap}; // R13
                `RTCAL_OFS_IEN:    next_s.rdata = {31'h0, s.ien};
                `RTCAL_OFS_ISTS:   next_s.rdata = {31'h0, s.flag};
                default:           next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata    = s.rdata;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign irq_alarm = s.flag && s.ien;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_cal_locked: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCAL_OFS_CAL && !s.wen && !tick) |=> $stable(s.cal))
        else $error("calendar changed while write access closed");

    chk_access_open: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `RTCAL_OFS_ACCESS && pwdata[15:0] == 16'hA965)
        |=> s.wen ##1 s.wen [*8])
        else $error("access window did not open");

    chk_access_close: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        (s.wen && s.wcnt == 10'h1FF && !(wr && paddr == `RTCAL_OFS_ACCESS))
        |=> !s.wen)
        else $error("access window not closed after 512 cycles");

    chk_hour_wrap24: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        (tick && s.active && s.fmt24 && !wr_tod && s.tod[21:0] == 22'h235959)
        |=> s.tod[21:0] == 22'h000000 && s.cal == $past(step_cal))
        else $error("24-hour rollover wrong");

    chk_hour_pm12: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        (tick && s.active && !s.fmt24 && !wr_tod && s.tod[21:0] == 22'h115959)
        |=> s.tod[21:16] == 6'h32 ##0 $stable(s.cal))
        else $error("12-hour noon code wrong");

    chk_wday_wrap: assert property ( // R18
        @(posedge pclk) disable iff (!presetn)
        (tick && s.active && s.fmt24 && !wr && s.tod[21:0] == 22'h235959
         && s.wday == 3'h6) |=> s.wday == 3'h0)
        else $error("weekday did not wrap to Sunday");

    chk_alarm_set: assert property ( // R15
        @(posedge pclk) disable iff (!presetn)
        (match && !s.match_q && s.ien) |=> s.flag ##1 (s.flag || $past(alarm_clr)))
        else $error("alarm flag not set on match");

    chk_alarm_hidden: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == `RTCAL_OFS_TALM && !s.active) |=> prdata == 32'h0)
        else $error("alarm readable while clock inactive");

    chk_leap_track: assert property ( // R16
        @(posedge pclk) disable iff (!presetn)
        ($stable(s.cal) && s.cal.year_tens_digit == 4'h2 && s.cal.year_units_digit == 4'h4)
        |-> s.leap)
        else $error("leap indicator wrong for year 24");
endmodule

`default_nettype wire

// file: rtc_calendar_alarm_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcal_params.svh"

module rtc_calendar_alarm_regs_tb;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_alarm;
    int          bad_count = 0;
    int          total_checks = 0;

    rtcal_regs #(.SECOND_CYCLES(10)) DUT (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .irq_alarm (irq_alarm)
    );

    always #50 pclk = ~pclk;

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        check(nm, d, exp);
    endtask

    task automatic unlock();
        wr(`RTCAL_OFS_ACCESS, 32'h0000A965);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rc("cal", `RTCAL_OFS_CAL, 32'h00050101);
        rc("fmt", `RTCAL_OFS_FMT, 32'h00000001);
        rc("wday", `RTCAL_OFS_WDAY, 32'h00000006);
        rc("leap", `RTCAL_OFS_LEAP, 32'h00000000);
        rc("talm", `RTCAL_OFS_TALM, 32'h00000000);
        rc("calm", `RTCAL_OFS_CALM, 32'h00000000);
        rc("time", `RTCAL_OFS_TIME, 32'h00000000);
        rc("status", `RTCAL_OFS_ISTS, 32'h00000000);
        check("irq", {31'h0, irq_alarm}, 32'h0);
        check("pready", {31'h0, pready}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_protect();
        logic [31:0] d;
        logic        e;
        rc("flag", `RTCAL_OFS_ACCESS, 32'h0);
        wr(`RTCAL_OFS_CAL, 32'h00991231);
        rc("cal locked", `RTCAL_OFS_CAL, 32'h00050101);
        unlock();
        rc("flag set", `RTCAL_OFS_ACCESS, 32'h00010000);
        wr(`RTCAL_OFS_CAL, 32'hFFFFFFFF);
        rc("cal fields", `RTCAL_OFS_CAL, 32'h00FF1F3F);
        wr(`RTCAL_OFS_LEAP, 32'h00000001);
        rc("leap ro", `RTCAL_OFS_LEAP, 32'h0);
        wr(`RTCAL_OFS_TALM, 32'h003F7F7F);
        wr(`RTCAL_OFS_CALM, 32'h00FF1F3F);
        rc("talm idle", `RTCAL_OFS_TALM, 32'h0);
        wr(`RTCAL_OFS_CTRL, 32'h1);
        rc("talm raw", `RTCAL_OFS_TALM, 32'h003F7F7F);
        rc("calm raw", `RTCAL_OFS_CALM, 32'h00FF1F3F);
        wr(`RTCAL_OFS_CTRL, 32'h0);
        wr(`RTCAL_OFS_ACCESS, 32'h00001234);
        rc("flag off", `RTCAL_OFS_ACCESS, 32'h0);
        wr(`RTCAL_OFS_CAL, 32'h00010101);
        rc("cal relock", `RTCAL_OFS_CAL, 32'h00FF1F3F);
        unlock();
        repeat (515) @(posedge pclk);
        rc("flag expiry", `RTCAL_OFS_ACCESS, 32'h0);
        apb(1'b0, 8'h3C, 32'h0, d, e);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", d, 32'h0);
        $display("test protect done");
    endtask

    task automatic t_roll(input logic f, input logic [31:0] t, input logic [31:0] c,
                          input logic [2:0] w, input logic [31:0] et, input logic [31:0] ec,
                          input logic [2:0] ew, input logic el);
        unlock();
        wr(`RTCAL_OFS_FMT, {31'h0, f});
        wr(`RTCAL_OFS_TIME, t);
        wr(`RTCAL_OFS_CAL, c);
        wr(`RTCAL_OFS_WDAY, {29'h0, w});
        wr(`RTCAL_OFS_CTRL, 32'h1);
        repeat (12) @(posedge pclk);
        wr(`RTCAL_OFS_CTRL, 32'h0);
        rc("time", `RTCAL_OFS_TIME, et);
        rc("cal run", `RTCAL_OFS_CAL, ec);
        rc("wday run", `RTCAL_OFS_WDAY, {29'h0, ew});
        rc("leap bit", `RTCAL_OFS_LEAP, {31'h0, el});
        $display("test roll done");
    endtask

    task automatic t_alarm();
        int n;
        unlock();
        wr(`RTCAL_OFS_IEN, 32'h1);
        wr(`RTCAL_OFS_FMT, 32'h0);
        wr(`RTCAL_OFS_TIME, 32'h00315959);
        wr(`RTCAL_OFS_CAL, 32'h00230228);
        wr(`RTCAL_OFS_TALM, 32'h00120000);
        wr(`RTCAL_OFS_CALM, 32'h00230301);
        wr(`RTCAL_OFS_ICLR, 32'h1);
        check("irq early", {31'h0, irq_alarm}, 32'h0);
        wr(`RTCAL_OFS_CTRL, 32'h1);
        n = 0;
        while (irq_alarm !== 1'b1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 40) begin
            bad_count++;
            end_of_test();
        end
        rc("status set", `RTCAL_OFS_ISTS, 32'h1);
        wr(`RTCAL_OFS_IEN, 32'h0);
        @(posedge pclk);
        #1;
        check("irq masked", {31'h0, irq_alarm}, 32'h0);
        rc("status sticky", `RTCAL_OFS_ISTS, 32'h1);
        wr(`RTCAL_OFS_ICLR, 32'h1);
        rc("status clear", `RTCAL_OFS_ISTS, 32'h0);
        wr(`RTCAL_OFS_CTRL, 32'h0);
        $display("test alarm done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_protect();
        t_roll(1'b1, 32'h00235959, 32'h00240228, 3'h6, 32'h0, 32'h00240229, 3'h0, 1'b1);
        t_roll(1'b1, 32'h00235959, 32'h00231231, 3'h1, 32'h0, 32'h00240101, 3'h2, 1'b1);
        t_roll(1'b0, 32'h00115959, 32'h00230228, 3'h2, 32'h00320000, 32'h00230228, 3'h2, 1'b0);
        t_roll(1'b0, 32'h00315959, 32'h00230228, 3'h3, 32'h00120000, 32'h00230301, 3'h4, 1'b0);
        t_roll(1'b0, 32'h00125959, 32'h00230228, 3'h2, 32'h00010000, 32'h00230228, 3'h2, 1'b0);
        t_roll(1'b0, 32'h00325959, 32'h00230228, 3'h2, 32'h00210000, 32'h00230228, 3'h2, 1'b0);
        t_alarm();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        end_of_test();
    end

endmodule

`default_nettype wire
